// File: adc_analog_model.sv
// comparator and single analog input standing for the converter's analog side
`timescale 1ns/1ps
module adc_analog_model
  import adc_conversion_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire analog_ctrl_t analog_in,
  input  wire logic [7:0]   level_in,
  output logic              comp_high_out
);
  logic noise;

  initial noise = 1'b0;

  // an unpowered comparator gives no answer, so it wanders every cycle
  always @(posedge mclk_in) noise <= ~noise;

  // one analog input only, held still by the bench during every conversion that runs to completion
  assign comp_high_out = analog_in.power_on ? (level_in >= analog_in.trial) : noise;
endmodule

// File: adc_conversion_control.sv
// successive-approximation converter control with register port and interrupt
`timescale 1ns/1ps
module adc_conversion_control
  import adc_conversion_pkg::*;
#(
  parameter logic [3:0] STEP_TICKS = STEP_TICKS_DEFAULT
)
(
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wire reg_req_t     bus_req_in,
  input  wire logic         comp_high_in,
  output logic [7:0]        rdata_out,
  output analog_ctrl_t      analog_out,
  output logic              busy_out,
  output logic              irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // comparator synchroniser
  logic comp_meta;
  logic comp_sync;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else
    begin
      comp_meta <= comp_high_in;
      comp_sync <= comp_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic     ctrl_wr;
  logic     start_req;
  logic     power_next;
  control_t control;

  assign ctrl_wr    = bus_req_in.wr && (bus_req_in.addr == CONTROL_ADDR);
  assign start_req  = ctrl_wr && bus_req_in.wdata[START_BIT];
  assign power_next = ctrl_wr ? bus_req_in.wdata[POWER_BIT] : control.converter_power_on;

  ////////////////////////////////////////////////////////////////////////////
  // converter sequencer
  conv_state_t state;
  conv_state_t next_state;
  logic [3:0]  div_cnt;
  logic [3:0]  next_div_cnt;
  logic [3:0]  step_cnt;
  logic [3:0]  next_step_cnt;
  logic [2:0]  bit_idx;
  logic [2:0]  next_bit_idx;
  logic [7:0]  trial;
  logic [7:0]  next_trial;
  logic [7:0]  result;
  logic [7:0]  next_result;
  logic [3:0]  div_last;
  logic        tick;
  logic        step_last;
  logic        done_evt;
  logic        abort_evt;

  assign div_last  = control.conversion_clock_select ? (DIV_FAST - 4'h1)
                                                     : (DIV_SLOW - 4'h1);
  // a ratio switch mid-step must not let the divider run past its end and wrap
  assign tick      = (state != ST_IDLE) && (div_cnt >= div_last);
  assign step_last = (step_cnt == (STEP_TICKS - 4'h1));

  always_comb
  begin
    next_state    = state;
    next_div_cnt  = tick ? 4'h0 : div_cnt + 4'h1;
    next_step_cnt = step_cnt;
    next_bit_idx  = bit_idx;
    next_trial    = trial;
    next_result   = result;
    done_evt      = 1'b0;
    abort_evt     = 1'b0;
    case (state)
      ST_IDLE:
      begin
        next_div_cnt = 4'h0;
      end
      ST_SAMPLE:
      begin
        if (tick)
        begin
          if (step_last)
          begin
            next_state    = ST_CONVERT;
            next_step_cnt = 4'h0;
            next_bit_idx  = 3'h7;
            next_trial    = 8'h80;
          end
          else
          begin
            next_step_cnt = step_cnt + 4'h1;
          end
        end
      end
      ST_CONVERT:
      begin
        if (tick)
        begin
          if (step_last)
          begin
            next_step_cnt = 4'h0;
            // comparator low means the trial overshoots the input
            if (!comp_sync)
            begin
              next_trial[bit_idx] = 1'b0;
            end
            if (bit_idx == 3'h0)
            begin
              next_result = next_trial;
              done_evt    = 1'b1;
              next_state  = ST_IDLE;
            end
            else
            begin
              next_trial[bit_idx - 3'h1] = 1'b1;
              next_bit_idx               = bit_idx - 3'h1;
            end
          end
          else
          begin
            next_step_cnt = step_cnt + 4'h1;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    // a restart or power-down throws away the partial result
    if (start_req && power_next)
    begin
      next_state    = ST_SAMPLE;
      next_div_cnt  = 4'h0;
      next_step_cnt = 4'h0;
      next_bit_idx  = 3'h7;
      next_trial    = 8'h00;
      next_result   = result;
      done_evt      = 1'b0;
      abort_evt     = (state != ST_IDLE);
    end
    else if (!power_next)
    begin
      next_state  = ST_IDLE;
      next_result = result;
      abort_evt   = (state != ST_IDLE);
      done_evt    = 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state    <= ST_IDLE;
      div_cnt  <= 4'h0;
      step_cnt <= 4'h0;
      bit_idx  <= 3'h7;
      trial    <= 8'h00;
      result   <= 8'h00;
    end
    else
    begin
      state    <= next_state;
      div_cnt  <= next_div_cnt;
      step_cnt <= next_step_cnt;
      bit_idx  <= next_bit_idx;
      trial    <= next_trial;
      result   <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and interrupt
  control_t             next_control;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] next_irq_status;
  logic [IRQ_WIDTH-1:0] irq_enable;
  logic [IRQ_WIDTH-1:0] next_irq_enable;
  logic [IRQ_WIDTH-1:0] irq_events;
  logic [IRQ_WIDTH-1:0] irq_clear;
  logic [7:0]           next_rdata;

  assign irq_events = {abort_evt, done_evt};
  assign irq_clear  = (bus_req_in.wr && (bus_req_in.addr == IRQ_CLEAR_ADDR))
                      ? bus_req_in.wdata[IRQ_WIDTH-1:0] : '0;

  always_comb
  begin
    next_control = control;
    if (ctrl_wr)
    begin
      // done flag is not writable; reserved bits are dropped
      next_control.done_irq_enable         = bus_req_in.wdata[IRQ_EN_BIT];
      next_control.converter_power_on      = bus_req_in.wdata[POWER_BIT];
      next_control.conversion_clock_select = bus_req_in.wdata[CLK_SEL_BIT];
    end
    if (start_req)
    begin
      next_control.done_flag = 1'b0;
    end
    if (done_evt)
    begin
      next_control.done_flag = 1'b1;
    end
    next_control.conversion_start_bit = 1'b0;
    next_control.reserved_3           = 1'b0;
    next_control.reserved_1_0         = 2'b00;

    // set wins over a clear in the same cycle
    next_irq_status = (irq_status & ~irq_clear) | irq_events;
    next_irq_enable = irq_enable;
    if (bus_req_in.wr && (bus_req_in.addr == IRQ_ENABLE_ADDR))
    begin
      next_irq_enable = bus_req_in.wdata[IRQ_WIDTH-1:0];
    end

    next_rdata = 8'h00;
    if (bus_req_in.rd)
    begin
      case (bus_req_in.addr)
        RESULT_ADDR:     next_rdata = result;
        CONTROL_ADDR:    next_rdata = control;
        IRQ_STATUS_ADDR: next_rdata = {{(8-IRQ_WIDTH){1'b0}}, irq_status};
        IRQ_ENABLE_ADDR: next_rdata = {{(8-IRQ_WIDTH){1'b0}}, irq_enable};
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      control    <= control_t'(CONTROL_RESET);
      irq_status <= '0;
      irq_enable <= '0;
      rdata_out  <= 8'h00;
    end
    else
    begin
      control    <= next_control;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      rdata_out  <= next_rdata;
    end
  end

  assign irq_out = (control.done_flag && control.done_irq_enable)
                   || |(irq_status & irq_enable);

  assign analog_out.power_on = control.converter_power_on;
  assign analog_out.sample   = (state == ST_SAMPLE);
  assign analog_out.trial    = trial;
  assign busy_out            = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking chk_clk @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  logic [3:0] tick_gap;
  always_ff @(posedge mclk_in)
  begin
    // a restart reloads the divider, so the gap starts over too
    if (rst_in || tick || state == ST_IDLE || start_req)
    begin
      tick_gap <= 4'h0;
    end
    else
    begin
      tick_gap <= tick_gap + 4'h1;
    end
  end

  sequence start_write_s;
    start_req && power_next;
  endsequence

  sequence finish_s;
    state == ST_CONVERT && tick && step_last && bit_idx == 3'h0 && !ctrl_wr;
  endsequence

  // the last tick of a conversion has no successor to time
  sequence fast_tick_s;
    tick && control.conversion_clock_select && !ctrl_wr
    && !(state == ST_CONVERT && step_last && bit_idx == 3'h0);
  endsequence

  start_clears_done_a: assert property (start_write_s |=> !control.done_flag)
    else $error("start did not clear done flag");

  finish_sets_done_a: assert property (finish_s |=> control.done_flag ##0 state == ST_IDLE)
    else $error("completion did not set done flag");

  single_shot_a: assert property ((finish_s ##1 !ctrl_wr[*3]) |-> state == ST_IDLE)
    else $error("converter ran without a new start");

  restart_abort_a: assert property ((busy_out && start_req && power_next)
                                    |=> state == ST_SAMPLE && step_cnt == 4'h0)
    else $error("restart did not begin a fresh conversion");

  start_reads_zero_a: assert property ((bus_req_in.rd && bus_req_in.addr == CONTROL_ADDR)
                                       |=> !rdata_out[START_BIT])
    else $error("start bit read back as one");

  irq_follows_done_a: assert property ($rose(control.done_flag) && control.done_irq_enable
                                       |-> irq_out)
    else $error("enabled completion raised no interrupt");

  done_readonly_a: assert property ((ctrl_wr && bus_req_in.wdata[DONE_BIT]
                                     && !control.done_flag && !done_evt)
                                    |=> !control.done_flag)
    else $error("software set the done flag");

  power_off_idle_a: assert property (!power_next |=> state == ST_IDLE)
    else $error("converter ran while powered down");

  fast_divide_a: assert property (fast_tick_s |=> (!tick)[*5])
    else $error("divide by six tick came early");

  fast_period_a: assert property ((fast_tick_s ##1 (!ctrl_wr)[*5]) |=> tick)
    else $error("divide by six tick came late");

  slow_divide_a: assert property (tick_gap <= (DIV_SLOW - 4'h1))
    else $error("conversion clock gap too long");

  reset_value_a: assert property ($fell(rst_in) |-> control == CONTROL_RESET
                                  && state == ST_IDLE && !irq_out)
    else $error("control reset value wrong");

  result_hold_a: assert property (!done_evt |=> $stable(result))
    else $error("result changed without completion");

endmodule

// File: adc_conversion_control_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_bench
  import adc_conversion_pkg::*;
;
  logic         mclk_in;
  logic         rst_in;
  reg_req_t     bus_req;
  logic         comp_high;
  logic [7:0]   rdata;
  analog_ctrl_t analog;
  logic         busy;
  logic         irq;
  logic [7:0]   level;
  logic [31:0]  rnd;
  int           num_errors;
  int           n_tests;
  int           cnt;

  // short steps keep a conversion at 9*d cycles
  adc_conversion_control #(.STEP_TICKS(4'h1)) adc_conversion_control_inst (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .bus_req_in   (bus_req),
    .comp_high_in (comp_high),
    .rdata_out    (rdata),
    .analog_out   (analog),
    .busy_out     (busy),
    .irq_out      (irq)
  );

  adc_analog_model adc_analog_model_inst (
    .mclk_in       (mclk_in),
    .analog_in     (analog),
    .level_in      (level),
    .comp_high_out (comp_high)
  );

  always #12.5 mclk_in = ~mclk_in;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus_req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    do
    begin
      @(posedge mclk_in);
      #1;
      n++;
    end while (busy === 1'b1 && n < 300);
    // a conversion that never ends counts as a mismatch
    if (busy !== 1'b0)
      num_errors++;
  endtask

  task automatic convert(input logic [7:0] ctl, input int d, input logic [7:0] lvl);
    level <= lvl;
    wr(CONTROL_ADDR, ctl);
    wait_idle(cnt);
    check(8'((cnt == 9 * d) || (cnt == 9 * d + 1)), 8'h01);
    rdchk(RESULT_ADDR, lvl);
    rdchk(CONTROL_ADDR, (ctl & 8'hdf) | 8'h40);
  endtask

  task automatic end_of_test;
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge mclk_in);
    num_errors++;
    end_of_test;
  end

  initial
  begin
    mclk_in = 1'b0;
    rst_in = 1'b1;
    bus_req = '0;
    level = 8'h00;
    rnd = 32'hf08b;
    num_errors = 0;
    n_tests = 0;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    rdchk(CONTROL_ADDR, CONTROL_RESET);
    rdchk(RESULT_ADDR, 8'h00);
    rdchk(8'hd7, 8'h00);
    wr(CONTROL_ADDR, 8'h10);
    check({7'h0, analog.power_on}, 8'h01);
    for (int i = 0; i < 10; i++)
    begin
      rnd = next_rand(rnd);
      convert(i[0] ? 8'h34 : 8'h30, i[0] ? 6 : 12,
              (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[7:0]);
    end
    repeat (20) @(posedge mclk_in);
    #1;
    check({7'h0, busy}, 8'h00);
    wr(CONTROL_ADDR, 8'h30);
    rdchk(CONTROL_ADDR, 8'h10);
    check({7'h0, analog.sample}, 8'h01);
    wait_idle(cnt);
    // restart partway: timing and result come from the second start only
    wr(CONTROL_ADDR, 8'h34);
    repeat (20) @(posedge mclk_in);
    convert(8'h34, 6, 8'h5a);
    rdchk(IRQ_STATUS_ADDR, 8'h03);
    wr(IRQ_CLEAR_ADDR, 8'h03);
    level <= 8'ha5;
    wr(CONTROL_ADDR, 8'h34);
    repeat (10) @(posedge mclk_in);
    wr(CONTROL_ADDR, 8'h00);
    wait_idle(cnt);
    rdchk(RESULT_ADDR, 8'h5a);
    rdchk(IRQ_STATUS_ADDR, 8'h02);
    // start while powered down, with a try at the read-only done bit
    wr(CONTROL_ADDR, 8'h60);
    repeat (5) @(posedge mclk_in);
    #1;
    check({7'h0, busy}, 8'h00);
    rdchk(CONTROL_ADDR, 8'h00);
    wr(IRQ_CLEAR_ADDR, 8'h03);
    wr(CONTROL_ADDR, 8'h10);
    rnd = next_rand(rnd);
    convert(8'hb4, 6, rnd[7:0]);
    check({7'h0, irq}, 8'h01);
    wr(CONTROL_ADDR, 8'h14);
    check({7'h0, irq}, 8'h00);
    rdchk(CONTROL_ADDR, 8'h54);
    wr(IRQ_ENABLE_ADDR, 8'h01);
    check({7'h0, irq}, 8'h01);
    rdchk(IRQ_ENABLE_ADDR, 8'h01);
    wr(IRQ_CLEAR_ADDR, 8'h01);
    check({7'h0, irq}, 8'h00);
    rdchk(IRQ_STATUS_ADDR, 8'h00);
    // reset in mid conversion
    wr(CONTROL_ADDR, 8'hb4);
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    check({7'h0, busy}, 8'h00);
    check({7'h0, irq}, 8'h00);
    rdchk(CONTROL_ADDR, CONTROL_RESET);
    end_of_test;
  end
endmodule

// File: adc_conversion_pkg.sv
// constants, field layouts and types of the converter control block
//
// Contract
// - successive approximation gives an eight-bit result
// - start write begins conversion, clears done flag
// - finished conversion sets the done flag
// - one conversion per start, no continuous mode
// - start during conversion abandons it, restarts
// - start bit always reads back as zero
// - interrupt on done only while enable set; irq_out also fires on done or abort status bits enabled at d4h
// - done flag is read-only to software
// - power bit on powers converter, off idles
// - clock select: divide by six, else twelve
// - reset stops conversion, control reads 40h
// - result register read-only at address d0h
package adc_conversion_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] RESULT_ADDR     = 8'hd0;
  localparam logic [7:0] CONTROL_ADDR    = 8'hd1;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'hd2;
  localparam logic [7:0] IRQ_CLEAR_ADDR  = 8'hd3;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hd4;

  localparam logic [7:0] CONTROL_RESET   = 8'h40;
  localparam int         IRQ_EN_BIT      = 7;
  localparam int         DONE_BIT        = 6;
  localparam int         START_BIT       = 5;
  localparam int         POWER_BIT       = 4;
  localparam int         CLK_SEL_BIT     = 2;

  localparam int         IRQ_WIDTH       = 2;
  localparam int         IRQ_DONE_BIT    = 0;
  localparam int         IRQ_ABORT_BIT   = 1;

  // conversion clock ratios against mclk
  localparam logic [3:0] DIV_SLOW        = 4'hc;
  localparam logic [3:0] DIV_FAST        = 4'h6;
  // conversion clocks spent per sample phase and per result bit
  localparam logic [3:0] STEP_TICKS_DEFAULT = 4'h5;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       done_irq_enable;
    logic       done_flag;
    logic       conversion_start_bit;
    logic       converter_power_on;
    logic       reserved_3;
    logic       conversion_clock_select;
    logic [1:0] reserved_1_0;
  } control_t;

  typedef struct packed {
    logic       power_on;
    logic       sample;
    logic [7:0] trial;
  } analog_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_t;

endpackage
